// *** logic/network_lane_rx_control_reg.sv ***
// network lane receive control register behind an mdio slave, with decoded controls
`timescale 1ns/1ps
module network_lane_rx_control_reg #(
   parameter int PORT_ADDR = 0,
   parameter int DEV_ADDR  = 1
) (
   input  wire logic                              clock,
   input  wire logic                              sys_rst,
   input  wire logic                              mdc,
   input  wire logic                              mdioIn,
   output logic                                   mdioOut,
   output logic                                   mdioOe,
   input  wire logic                              moduleResetLow,
   input  wire logic                              tenLaneMode,
   input  wire logic                              prbsExtendedMode,
   output logic [net_rx_ctrl_pkg::REG_W-1:0]      controlWord,
   output logic                                   decisionActive,
   output logic                                   prbsCheckEnable,
   output logic [4:0]                             prbsOrder,
   output logic                                   mclkLockToRef,
   output logic                                   loopbackEnable,
   output logic                                   fifoAutoReset,
   output logic                                   rxPathReset,
   output logic                                   fifoReset,
   output logic [net_rx_ctrl_pkg::DIV_W-1:0]      mclkDivider,
   output logic                                   mclkFromHost,
   output logic [2:0]                             rateCode,
   output logic                                   rateValid,
   output logic [net_rx_ctrl_pkg::DIV_W-1:0]      refclkDivider
);
   import net_rx_ctrl_pkg::*;

   if (PORT_ADDR < 0 || PORT_ADDR > 31 || DEV_ADDR < 0 || DEV_ADDR > 31) begin : g_check
      $error("mdio port and device address must each fit in five bits");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] mdcSync_q;
   logic [1:0] mdioSync_q;
   logic [1:0] modRstSync_q;
   logic       coreReset;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mdcSync_q    <= 2'b00;
         mdioSync_q   <= 2'b11;
         modRstSync_q <= 2'b00;
      end else begin
         mdcSync_q    <= {mdcSync_q[0], mdc};
         mdioSync_q   <= {mdioSync_q[0], mdioIn};
         modRstSync_q <= {modRstSync_q[0], moduleResetLow};
      end
   end

   // low on the module reset pin holds everything past the pin synchronisers at reset values
   assign coreReset = sys_rst | ~modRstSync_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   // mdio frame engine
   reg_access_if regBus ();

   mdio_frame_slave #(
      .PORT_ADDR (PORT_ADDR[4:0]),
      .DEV_ADDR  (DEV_ADDR[4:0])
   ) u_frame (
      .clock     (clock),
      .sys_rst   (coreReset),
      .mdcLevel  (mdcSync_q[1]),
      .mdioLevel (mdioSync_q[1]),
      .mdioOut   (mdioOut),
      .mdioOe    (mdioOe),
      .bus       (regBus.master)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // control register
   logic [15:0] ctrl_q, ctrl_d;

   always_comb begin
      ctrl_d = ctrl_q;
      if (regBus.writeStrobe && regBus.address == RX_CTRL_ADDR) begin
         ctrl_d = regBus.writeData;
      end
   end

   always_ff @(posedge clock) begin
      if (coreReset) begin
         ctrl_q <= RX_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // unmapped addresses read as zero
   always_comb begin
      if (regBus.address == RX_CTRL_ADDR) begin
         regBus.readData = ctrl_q;
      end else begin
         regBus.readData = 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field decode
   logic [4:0] prbsOrder_q, prbsOrder_d;
   logic [7:0] mclkDiv_q, mclkDiv_d;
   logic       mclkHost_q, mclkHost_d;
   logic       rateValid_q, rateValid_d;
   logic [7:0] refDiv_q, refDiv_d;
   logic [1:0] patCode;
   logic [2:0] mclkCode;
   logic [2:0] rateSel;

   assign patCode  = ctrl_q[PRBS_PAT_HI:PRBS_PAT_LO];
   assign mclkCode = ctrl_q[MCLK_SEL_HI:MCLK_SEL_LO];
   assign rateSel  = ctrl_q[RATE_HI:RATE_LO];

   always_comb begin
      if (prbsExtendedMode) begin
         prbsOrder_d = (patCode == 2'b00) ? PRBS_9 : PRBS_RESERVED;
      end else begin
         case (patCode)
            2'b00:   prbsOrder_d = PRBS_7;
            2'b01:   prbsOrder_d = PRBS_15;
            2'b10:   prbsOrder_d = PRBS_23;
            default: prbsOrder_d = PRBS_31;
         endcase
      end
      mclkHost_d = 1'b0;
      case (mclkCode)
         3'b001:  mclkDiv_d = tenLaneMode ? DIV_NONE : DIV_32;
         3'b010:  mclkDiv_d = DIV_8;
         3'b100:  mclkDiv_d = tenLaneMode ? DIV_64 : DIV_NONE;
         3'b110:  mclkDiv_d = tenLaneMode ? DIV_16 : DIV_NONE;
         3'b101: begin
            mclkDiv_d  = tenLaneMode ? DIV_64 : DIV_160;
            mclkHost_d = 1'b1;
         end
         3'b111: begin
            mclkDiv_d  = tenLaneMode ? DIV_16 : DIV_40;
            mclkHost_d = 1'b1;
         end
         default: mclkDiv_d = DIV_NONE;
      endcase
      case (rateSel)
         3'b000, 3'b011:                 rateValid_d = 1'b1;
         3'b001, 3'b010, 3'b100, 3'b101: rateValid_d = tenLaneMode;
         default:                        rateValid_d = 1'b0;
      endcase
      if (ctrl_q[REFDIV_BIT]) begin
         refDiv_d = tenLaneMode ? DIV_64 : DIV_160;
      end else begin
         refDiv_d = tenLaneMode ? DIV_16 : DIV_40;
      end
   end

   always_ff @(posedge clock) begin
      if (coreReset) begin
         prbsOrder_q <= PRBS_RESERVED;
         mclkDiv_q   <= DIV_NONE;
         mclkHost_q  <= 1'b0;
         rateValid_q <= 1'b0;
         refDiv_q    <= DIV_NONE;
      end else begin
         prbsOrder_q <= prbsOrder_d;
         mclkDiv_q   <= mclkDiv_d;
         mclkHost_q  <= mclkHost_d;
         rateValid_q <= rateValid_d;
         refDiv_q    <= refDiv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign controlWord     = ctrl_q;
   assign decisionActive  = ctrl_q[DECISION_BIT];
   assign prbsCheckEnable = ctrl_q[PRBS_EN_BIT];
   assign prbsOrder       = prbsOrder_q;
   assign mclkLockToRef   = ctrl_q[MCLK_LOCK_BIT];
   assign loopbackEnable  = ctrl_q[LOOPBACK_BIT];
   assign fifoAutoReset   = ctrl_q[FIFO_AUTO_BIT];
   assign rxPathReset     = ctrl_q[RX_RESET_BIT];
   // a held receive path reset also holds the fifo
   assign fifoReset       = ctrl_q[FIFO_RESET_BIT] | ctrl_q[RX_RESET_BIT];
   assign mclkDivider     = mclkDiv_q;
   assign mclkFromHost    = mclkHost_q;
   assign rateCode        = ctrl_q[RATE_HI:RATE_LO];
   assign rateValid       = rateValid_q;
   assign refclkDivider   = refDiv_q;
endmodule

// *** logic/net_rx_ctrl_pkg.sv ***
// constants, field positions and decode values for the network lane receive control register
package net_rx_ctrl_pkg;
   localparam int          REG_W          = 16;
   localparam int          DIV_W          = 8;
   localparam logic [15:0] RX_CTRL_ADDR   = 16'hA012;
   localparam logic [15:0] RX_CTRL_RESET  = 16'h0200;
   localparam logic [15:0] MDIO_ADDR_RESET = 16'h0000;
   localparam int          DECISION_BIT   = 15;
   localparam int          PRBS_EN_BIT    = 14;
   localparam int          PRBS_PAT_HI    = 13;
   localparam int          PRBS_PAT_LO    = 12;
   localparam int          MCLK_LOCK_BIT  = 11;
   localparam int          LOOPBACK_BIT   = 10;
   localparam int          FIFO_AUTO_BIT  = 9;
   localparam int          RX_RESET_BIT   = 8;
   localparam int          MCLK_SEL_HI    = 7;
   localparam int          MCLK_SEL_LO    = 5;
   localparam int          FIFO_RESET_BIT = 4;
   localparam int          RATE_HI        = 3;
   localparam int          RATE_LO        = 1;
   localparam int          REFDIV_BIT     = 0;
   // mdio clause 45 frame layout
   localparam logic [5:0]  PREAMBLE_BITS  = 6'd32;
   localparam logic [5:0]  HEADER_BITS    = 6'd14;
   localparam logic [5:0]  DATA_BITS      = 6'd16;
   localparam logic [1:0]  ST_CODE        = 2'b00;
   localparam logic [1:0]  OP_ADDRESS     = 2'b00;
   localparam logic [1:0]  OP_WRITE       = 2'b01;
   localparam logic [1:0]  OP_READ_INC    = 2'b10;
   localparam logic [1:0]  OP_READ        = 2'b11;
   // divider values, zero means disabled or reserved
   localparam logic [7:0]  DIV_NONE       = 8'h00;
   localparam logic [7:0]  DIV_8          = 8'h08;
   localparam logic [7:0]  DIV_16         = 8'h10;
   localparam logic [7:0]  DIV_32         = 8'h20;
   localparam logic [7:0]  DIV_40         = 8'h28;
   localparam logic [7:0]  DIV_64         = 8'h40;
   localparam logic [7:0]  DIV_160        = 8'hA0;
   // prbs polynomial orders, zero means reserved
   localparam logic [4:0]  PRBS_RESERVED  = 5'h00;
   localparam logic [4:0]  PRBS_7         = 5'h07;
   localparam logic [4:0]  PRBS_9         = 5'h09;
   localparam logic [4:0]  PRBS_15        = 5'h0F;
   localparam logic [4:0]  PRBS_23        = 5'h17;
   localparam logic [4:0]  PRBS_31        = 5'h1F;
endpackage

// *** logic/reg_access_if.sv ***
// register access carrier between the mdio frame engine and the register file
`timescale 1ns/1ps
interface reg_access_if;
   logic [15:0] address;
   logic [15:0] writeData;
   logic        writeStrobe;
   logic [15:0] readData;
   modport master (output address, output writeData, output writeStrobe, input readData);
   modport target (input address, input writeData, input writeStrobe, output readData);
endinterface

// *** logic/mdio_frame_slave.sv ***
// clause 45 mdio frame engine working on synchronised mdc and mdio levels
`timescale 1ns/1ps
module mdio_frame_slave #(
   parameter logic [4:0] PORT_ADDR = 5'h00,
   parameter logic [4:0] DEV_ADDR  = 5'h01
) (
   input  wire logic     clock,
   input  wire logic     sys_rst,
   input  wire logic     mdcLevel,
   input  wire logic     mdioLevel,
   output logic          mdioOut,
   output logic          mdioOe,
   reg_access_if.master  bus
);
   import net_rx_ctrl_pkg::*;

   typedef enum logic [1:0] {PREAMBLE, HEADER, TURNAROUND, DATA} frame_state_t;

   frame_state_t state_q, state_d;
   logic [5:0]   cnt_q, cnt_d;
   logic [15:0]  shift_q, shift_d;
   logic [15:0]  addr_q, addr_d;
   logic [15:0]  txData_q, txData_d;
   logic [1:0]   op_q, op_d;
   logic         match_q, match_d;
   logic         out_q, out_d;
   logic         oe_q, oe_d;
   logic         write_q, write_d;
   logic         mdcPrev_q;
   logic         rise;
   logic         reading;

   assign rise    = mdcLevel & ~mdcPrev_q;
   assign reading = match_q & op_q[1];

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      shift_d  = shift_q;
      addr_d   = addr_q;
      txData_d = txData_q;
      op_d     = op_q;
      match_d  = match_q;
      out_d    = out_q;
      oe_d     = oe_q;
      write_d  = 1'b0;
      if (rise) begin
         case (state_q)
            PREAMBLE: begin
               if (mdioLevel) begin
                  if (cnt_q < PREAMBLE_BITS) begin
                     cnt_d = cnt_q + 6'd1;
                  end
               end else if (cnt_q == PREAMBLE_BITS) begin
                  // this zero is the first start bit
                  state_d = HEADER;
                  cnt_d   = 6'd1;
                  shift_d = 16'h0000;
               end else begin
                  cnt_d = 6'd0;
               end
            end
            HEADER: begin
               shift_d = {shift_q[14:0], mdioLevel};
               cnt_d   = cnt_q + 6'd1;
               if (cnt_q == HEADER_BITS - 6'd1) begin
                  state_d = TURNAROUND;
                  cnt_d   = 6'd0;
                  op_d    = shift_d[11:10];
                  match_d = (shift_d[13:12] == ST_CODE) && (shift_d[9:5] == PORT_ADDR)
                            && (shift_d[4:0] == DEV_ADDR);
               end
            end
            TURNAROUND: begin
               cnt_d = cnt_q + 6'd1;
               if (cnt_q == 6'd0) begin
                  if (reading) begin
                     oe_d     = 1'b1;
                     out_d    = 1'b0;
                     txData_d = bus.readData;
                  end
               end else begin
                  state_d = DATA;
                  cnt_d   = 6'd0;
                  if (reading) begin
                     out_d    = txData_q[15];
                     txData_d = {txData_q[14:0], 1'b0};
                  end
               end
            end
            DATA: begin
               shift_d = {shift_q[14:0], mdioLevel};
               cnt_d   = cnt_q + 6'd1;
               if (cnt_q == DATA_BITS - 6'd1) begin
                  state_d = PREAMBLE;
                  cnt_d   = 6'd0;
                  oe_d    = 1'b0;
                  out_d   = 1'b0;
                  if (match_q) begin
                     if (op_q == OP_ADDRESS) begin
                        addr_d = shift_d;
                     end else if (op_q == OP_WRITE) begin
                        write_d = 1'b1;
                     end else if (op_q == OP_READ_INC) begin
                        addr_d = addr_q + 16'h0001;
                     end
                  end
               end else if (reading) begin
                  out_d    = txData_q[15];
                  txData_d = {txData_q[14:0], 1'b0};
               end
            end
            default: begin
               state_d = PREAMBLE;
               cnt_d   = 6'd0;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q   <= PREAMBLE;
         cnt_q     <= 6'd0;
         shift_q   <= 16'h0000;
         addr_q    <= MDIO_ADDR_RESET;
         txData_q  <= 16'h0000;
         op_q      <= 2'b00;
         match_q   <= 1'b0;
         out_q     <= 1'b0;
         oe_q      <= 1'b0;
         write_q   <= 1'b0;
         mdcPrev_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         shift_q   <= shift_d;
         addr_q    <= addr_d;
         txData_q  <= txData_d;
         op_q      <= op_d;
         match_q   <= match_d;
         out_q     <= out_d;
         oe_q      <= oe_d;
         write_q   <= write_d;
         mdcPrev_q <= mdcLevel;
      end
   end

   assign mdioOut         = out_q;
   assign mdioOe          = oe_q;
   assign bus.address     = addr_q;
   assign bus.writeData   = shift_q;
   assign bus.writeStrobe = write_q;
endmodule

// *** tb/network_lane_rx_control_reg_properties.sv ***
// concurrent checks on the receive control register ports
`timescale 1ns/1ps
module network_lane_rx_control_reg_properties (
   input wire logic                  clock,
   input wire logic                  sys_rst,
   input wire logic                  moduleResetLow,
   input wire logic                  tenLaneMode,
   input wire logic                  prbsExtendedMode,
   input wire logic [net_rx_ctrl_pkg::REG_W-1:0] controlWord,
   input wire logic                  decisionActive,
   input wire logic                  prbsCheckEnable,
   input wire logic [4:0]            prbsOrder,
   input wire logic                  mclkLockToRef,
   input wire logic                  loopbackEnable,
   input wire logic                  fifoAutoReset,
   input wire logic                  rxPathReset,
   input wire logic                  fifoReset,
   input wire logic [net_rx_ctrl_pkg::DIV_W-1:0] mclkDivider,
   input wire logic                  mclkFromHost,
   input wire logic [2:0]            rateCode,
   input wire logic [net_rx_ctrl_pkg::DIV_W-1:0] refclkDivider
);
   import net_rx_ctrl_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // cycles since either reset was last seen active, saturating at 7
   logic [2:0] upCnt_q;
   logic [2:0] upCnt_d;
   always_comb begin
      upCnt_d = upCnt_q;
      if (sys_rst || !moduleResetLow) upCnt_d = 3'h0;
      else if (upCnt_q != 3'h7) upCnt_d = upCnt_q + 3'h1;
   end
   always_ff @(posedge clock) begin
      upCnt_q <= upCnt_d;
   end
   sequence settled;
      upCnt_q == 3'h7 && $stable(controlWord) && $stable(tenLaneMode)
         && $stable(prbsExtendedMode);
   endsequence
   sequence pinHeld;
      !moduleResetLow [*6];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   AST_DECISION: assert property (decisionActive == controlWord[DECISION_BIT])
      else $error("decision output wrong");
   AST_PRBS_EN: assert property (prbsCheckEnable == controlWord[PRBS_EN_BIT])
      else $error("prbs enable wrong");
   AST_LOCK: assert property (mclkLockToRef == controlWord[MCLK_LOCK_BIT])
      else $error("lock output wrong");
   AST_LOOP: assert property (loopbackEnable == controlWord[LOOPBACK_BIT])
      else $error("loopback output wrong");
   AST_AUTO: assert property (fifoAutoReset == controlWord[FIFO_AUTO_BIT])
      else $error("fifo auto reset wrong");
   AST_RX_RESET: assert property (rxPathReset == controlWord[RX_RESET_BIT])
      else $error("rx reset wrong");
   AST_FIFO_RESET: assert property (fifoReset == (controlWord[4] | controlWord[8]))
      else $error("fifo reset wrong");
   AST_RATE: assert property (rateCode == controlWord[RATE_HI:RATE_LO])
      else $error("rate code wrong");
   AST_REFDIV: assert property (settled |-> refclkDivider == (controlWord[0] ?
      (tenLaneMode ? DIV_64 : DIV_160) : (tenLaneMode ? DIV_16 : DIV_40)))
      else $error("reference divider wrong");
   AST_MCLK_HOST: assert property (settled |-> mclkFromHost ==
      (controlWord[7:5] == 3'h5 || controlWord[7:5] == 3'h7)) else $error("host mclk wrong");
   AST_MCLK_8: assert property (settled ##0 controlWord[7:5] == 3'h2 |->
      mclkDivider == DIV_8) else $error("mclk divider wrong");
   AST_PRBS_EXT: assert property (settled ##0 prbsExtendedMode |-> prbsOrder ==
      (controlWord[13:12] == 2'h0 ? PRBS_9 : PRBS_RESERVED)) else $error("extended order wrong");
   AST_RESET_VAL: assert property (pinHeld |-> controlWord == RX_CTRL_RESET)
      else $error("reset value wrong");
endmodule
bind network_lane_rx_control_reg network_lane_rx_control_reg_properties props_inst (.*);

// *** tb/mdio_master_model.sv ***
// mdio management master with a pull-up on the shared data line
`timescale 1ns/1ps
module mdio_master_model (
   input  wire logic clock,
   output logic      mdc,
   output logic      mdioLine,
   input  wire logic mdioOut,
   input  wire logic mdioOe
);
   logic drive = 1'b0;
   logic bitOut = 1'b1;
   initial mdc = 1'b0;
   // released line rests at the pull-up level
   assign mdioLine = mdioOe ? mdioOut : (drive ? bitOut : 1'b1);
   task automatic frame(input logic [1:0] op, input logic [4:0] dev,
                        input logic [15:0] data, output logic [15:0] rdata);
      logic [63:0] bits;
      bits = {32'hFFFFFFFF, 2'b00, op, 5'h00, dev, 2'b10, data};
      rdata = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         @(posedge clock);
         drive <= !(op[1] && i < 18);
         bitOut <= bits[i];
         repeat (5) @(posedge clock);
         mdc <= 1'b1;
         if (i < 16) rdata[i] = mdioLine;
         repeat (5) @(posedge clock);
         mdc <= 1'b0;
      end
      @(posedge clock);
      drive <= 1'b0;
   endtask
endmodule

// *** tb/network_lane_rx_control_reg_bench.sv ***
// self-checking bench for the receive control register
`timescale 1ns/1ps
module network_lane_rx_control_reg_bench;
   import net_rx_ctrl_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, moduleResetLow = 1'b1, ten = 1'b0, ext = 1'b0;
   logic mdc, mdioIn, mdioOut, mdioOe, decisionActive, prbsCheckEnable, mclkLockToRef;
   logic loopbackEnable, fifoAutoReset, rxPathReset, fifoReset, mclkFromHost, rateValid;
   logic [15:0] controlWord, w, rd;
   logic [7:0]  mclkDivider, refclkDivider;
   logic [4:0]  prbsOrder;
   logic [2:0]  rateCode;
   int num_errors = 0, checks = 0, cycles = 0, model = 32'h0200;
   integer seed = 88872;
   always #4 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   mdio_master_model mdio_master_model_inst (.clock(clock), .mdc(mdc), .mdioLine(mdioIn),
      .mdioOut(mdioOut), .mdioOe(mdioOe));
   network_lane_rx_control_reg network_lane_rx_control_reg_inst (.clock(clock),
      .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .moduleResetLow(moduleResetLow), .tenLaneMode(ten), .prbsExtendedMode(ext),
      .controlWord(controlWord), .decisionActive(decisionActive), .prbsOrder(prbsOrder),
      .prbsCheckEnable(prbsCheckEnable), .mclkLockToRef(mclkLockToRef),
      .loopbackEnable(loopbackEnable), .fifoAutoReset(fifoAutoReset), .rateCode(rateCode),
      .rxPathReset(rxPathReset), .fifoReset(fifoReset), .mclkDivider(mclkDivider),
      .mclkFromHost(mclkFromHost), .rateValid(rateValid), .refclkDivider(refclkDivider));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic int mclkOf(int w, int t);
      case (w >> 5 & 7)
         1: return t ? 0 : 32;
         2: return 8;
         4: return t ? 64 : 0;
         5: return t ? 64 : 160;
         6: return t ? 16 : 0;
         7: return t ? 16 : 40;
         default: return 0;
      endcase
   endfunction
   function automatic int validOf(int w, int t);
      int r;
      r = w >> 1 & 7;
      return (r == 0 || r == 3) ? 1 : ((r > 5) ? 0 : t);
   endfunction
   task automatic checkWord(string n, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic checkField(string n, int e, logic [7:0] g);
      checkWord(n, 16'(e), {8'h00, g});
   endtask
   task automatic checkAll();
      int t, x, p;
      t = ten;
      x = ext;
      p = model >> 12 & 3;
      checkWord("controlWord", model[15:0], controlWord);
      checkField("decision", model >> 15 & 1, 8'(decisionActive));
      checkField("prbsEnable", model >> 14 & 1, 8'(prbsCheckEnable));
      checkField("prbsOrder", x ? (p == 0 ? 9 : 0) : 8 * p + 7, 8'(prbsOrder));
      checkField("lock", model >> 11 & 1, 8'(mclkLockToRef));
      checkField("loopback", model >> 10 & 1, 8'(loopbackEnable));
      checkField("autoReset", model >> 9 & 1, 8'(fifoAutoReset));
      checkField("rxReset", model >> 8 & 1, 8'(rxPathReset));
      checkField("fifoReset", (model >> 4 | model >> 8) & 1, 8'(fifoReset));
      checkField("mclkDivider", mclkOf(model, t), mclkDivider);
      checkField("mclkHost", int'((model >> 5 & 5) == 5), 8'(mclkFromHost));
      checkField("rateCode", model >> 1 & 7, 8'(rateCode));
      checkField("rateValid", validOf(model, t), 8'(rateValid));
      checkField("refDivider", (model & 1) ? (t ? 64 : 160) : (t ? 16 : 40),
         refclkDivider);
   endtask
   task automatic access(logic [4:0] dev, logic [15:0] a, logic [1:0] op, logic [15:0] d);
      mdio_master_model_inst.frame(OP_ADDRESS, dev, a, rd);
      mdio_master_model_inst.frame(op, dev, d, rd);
      repeat (3) @(posedge clock);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      cycles++;
      if (cycles == 70000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clock);
      checkAll();
      access(5'h01, RX_CTRL_ADDR, OP_READ, 16'h0000);
      checkWord("readback", model[15:0], rd);
      for (int i = 0; i < 16; i++) begin
         w = 16'($random(seed));
         w[13:12] = i[1:0];
         w[7:5] = i[2:0];
         w[3:1] = i[2:0];
         ten <= i[3];
         ext <= i[2];
         access(5'h01, RX_CTRL_ADDR, OP_WRITE, w);
         model = w;
         checkAll();
         access(5'h01, RX_CTRL_ADDR, OP_READ, 16'h0000);
         checkWord("readback", w, rd);
      end
      // unmapped place and foreign device address leave the register alone
      access(5'h01, 16'hA013, OP_WRITE, 16'h5A5A);
      access(5'h01, 16'hA013, OP_READ, 16'hFFFF);
      checkWord("unmapped", 16'h0000, rd);
      access(5'h02, RX_CTRL_ADDR, OP_WRITE, ~model[15:0]);
      checkAll();
      access(5'h01, RX_CTRL_ADDR, OP_READ_INC, 16'h0000);
      checkWord("readInc", model[15:0], rd);
      mdio_master_model_inst.frame(OP_READ, 5'h01, 16'h0000, rd);
      checkWord("afterInc", 16'h0000, rd);
      moduleResetLow <= 1'b0;
      repeat (8) @(posedge clock);
      moduleResetLow <= 1'b1;
      repeat (8) @(posedge clock);
      model = 32'h0200;
      checkAll();
      access(5'h01, RX_CTRL_ADDR, OP_READ, 16'h0000);
      checkWord("resetRead", 16'h0200, rd);
      print_verdict();
   end
endmodule
